// ---- core/pcg_top.v ----
// Purpose: peripheral clock gating with six AXI4-Lite disable registers
// Assumes: one aclk; peripheral clocks arrive on periph_clk_in
// Notes:   absent peripherals are masked by a presence parameter
//
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "pcg_map.vh"
module pcg_top #(
    parameter [191:0] PRESENT = {6{32'hFFFFFFFF}}
) (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [4:0]  s_axi_awaddr,
    input  wire [2:0]  s_axi_awprot,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [4:0]  s_axi_araddr,
    input  wire [2:0]  s_axi_arprot,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire [32:0] periph_clk_in,
    output wire [32:0] periph_clk_out,
    output wire [32:0] periph_gate_off,
    output wire [32:0] periph_regs_blocked
);
    reg  [31:0] gate_analog_group;
    reg  [31:0] gate_comparator_group;
    reg  [31:0] gate_capture_compare_group;
    reg  [31:0] gate_timer_group;
    reg  [31:0] gate_serial_group;
    reg  [31:0] gate_misc_group;

    reg         aw_held;
    reg  [4:0]  aw_addr;
    reg         w_held;
    reg  [31:0] w_data;
    reg  [3:0]  w_strb;

    wire [191:0] present_mask;
    assign present_mask = PRESENT & {
        `PCG_MASK_MISC,
        `PCG_MASK_SERIAL,
        `PCG_MASK_TIMER,
        `PCG_MASK_CAPCMP,
        `PCG_MASK_COMPARATOR,
        `PCG_MASK_ANALOG
    };

    // Address and data are captured independently, one write in flight
    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;

    wire        aw_now;
    wire        w_now;
    wire [4:0]  wr_addr;
    wire [31:0] wr_data;
    wire [3:0]  wr_strb;
    wire        wr_fire;
    assign aw_now  = aw_held | (s_axi_awvalid & s_axi_awready);
    assign w_now   = w_held | (s_axi_wvalid & s_axi_wready);
    assign wr_addr = aw_held ? aw_addr : s_axi_awaddr;
    assign wr_data = w_held ? w_data : s_axi_wdata;
    assign wr_strb = w_held ? w_strb : s_axi_wstrb;
    assign wr_fire = aw_now & w_now & ~s_axi_bvalid;

    wire [31:0] strb_mask;
    assign strb_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}},
                        {8{wr_strb[1]}}, {8{wr_strb[0]}}};

    reg  [2:0]  wr_sel;
    reg         wr_hit;
    always @* begin
        wr_sel = 3'h0;
        wr_hit = 1'b1;
        if ({wr_addr[4:2], 2'h0} == `PCG_OFS_ANALOG) begin
            wr_sel = 3'h0;
        end else if ({wr_addr[4:2], 2'h0} == `PCG_OFS_COMPARATOR) begin
            wr_sel = 3'h1;
        end else if ({wr_addr[4:2], 2'h0} == `PCG_OFS_CAPCMP) begin
            wr_sel = 3'h2;
        end else if ({wr_addr[4:2], 2'h0} == `PCG_OFS_TIMER) begin
            wr_sel = 3'h3;
        end else if ({wr_addr[4:2], 2'h0} == `PCG_OFS_SERIAL) begin
            wr_sel = 3'h4;
        end else if ({wr_addr[4:2], 2'h0} == `PCG_OFS_MISC) begin
            wr_sel = 3'h5;
        end else begin
            wr_hit = 1'b0;
        end
    end

    function [31:0] merge;
        input [31:0] old;
        input [31:0] val;
        input [31:0] strb;
        input [31:0] keep;
        begin
            merge = ((old & ~strb) | (val & strb)) & keep;
        end
    endfunction

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= 5'h00;
            w_held  <= 1'b0;
            w_data  <= 32'h00000000;
            w_strb  <= 4'h0;
        end else if (wr_fire) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
        end else begin
            if (s_axi_awvalid & s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            gate_analog_group          <= `PCG_RESET_VALUE;
            gate_comparator_group      <= `PCG_RESET_VALUE;
            gate_capture_compare_group <= `PCG_RESET_VALUE;
            gate_timer_group           <= `PCG_RESET_VALUE;
            gate_serial_group          <= `PCG_RESET_VALUE;
            gate_misc_group            <= `PCG_RESET_VALUE;
        end else if (wr_fire && wr_hit) begin
            case (wr_sel)
                3'h0: begin
                    gate_analog_group <= merge(gate_analog_group, wr_data,
                                               strb_mask, present_mask[31:0]);
                end
                3'h1: begin
                    gate_comparator_group <= merge(gate_comparator_group, wr_data,
                                                   strb_mask, present_mask[63:32]);
                end
                3'h2: begin
                    gate_capture_compare_group <= merge(gate_capture_compare_group,
                                                        wr_data, strb_mask,
                                                        present_mask[95:64]);
                end
                3'h3: begin
                    gate_timer_group <= merge(gate_timer_group, wr_data,
                                              strb_mask, present_mask[127:96]);
                end
                3'h4: begin
                    gate_serial_group <= merge(gate_serial_group, wr_data,
                                               strb_mask, present_mask[159:128]);
                end
                default: begin
                    gate_misc_group <= merge(gate_misc_group, wr_data,
                                             strb_mask, present_mask[191:160]);
                end
            endcase
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `PCG_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `PCG_RESP_OKAY : `PCG_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    reg [31:0] rd_word;
    reg        rd_hit;
    always @* begin
        rd_word = 32'h00000000;
        rd_hit  = 1'b1;
        if ({s_axi_araddr[4:2], 2'h0} == `PCG_OFS_ANALOG) begin
            rd_word = gate_analog_group;
        end else if ({s_axi_araddr[4:2], 2'h0} == `PCG_OFS_COMPARATOR) begin
            rd_word = gate_comparator_group;
        end else if ({s_axi_araddr[4:2], 2'h0} == `PCG_OFS_CAPCMP) begin
            rd_word = gate_capture_compare_group;
        end else if ({s_axi_araddr[4:2], 2'h0} == `PCG_OFS_TIMER) begin
            rd_word = gate_timer_group;
        end else if ({s_axi_araddr[4:2], 2'h0} == `PCG_OFS_SERIAL) begin
            rd_word = gate_serial_group;
        end else if ({s_axi_araddr[4:2], 2'h0} == `PCG_OFS_MISC) begin
            rd_word = gate_misc_group;
        end else begin
            rd_hit = 1'b0;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `PCG_RESP_OKAY;
        end else if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_hit ? `PCG_RESP_OKAY : `PCG_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // One named lane per peripheral, lowest lane first
    wire        adc_gate_off;
    wire        charge_time_unit_gate_off;
    wire        cmp_vref_gate_off;

    wire        comparator1_gate_off;
    wire        comparator2_gate_off;

    wire        capture1_gate_off;
    wire        capture2_gate_off;
    wire        capture3_gate_off;
    wire        capture4_gate_off;
    wire        capture5_gate_off;
    wire        compare1_gate_off;
    wire        compare2_gate_off;
    wire        compare3_gate_off;
    wire        compare4_gate_off;
    wire        compare5_gate_off;

    wire        timer1_gate_off;
    wire        timer2_gate_off;
    wire        timer3_gate_off;
    wire        timer4_gate_off;
    wire        timer5_gate_off;

    wire        uart1_gate_off;
    wire        uart2_gate_off;
    wire        uart3_gate_off;
    wire        uart4_gate_off;
    wire        uart5_gate_off;
    wire        spi1_gate_off;
    wire        spi2_gate_off;
    wire        i2c1_gate_off;
    wire        i2c2_gate_off;
    wire        usb_gate_off;

    wire        rtc_gate_off;
    wire        refclk_out_gate_off;
    wire        parallel_port_gate_off;

    assign adc_gate_off              = gate_analog_group[`PCG_BIT_ADC];
    assign charge_time_unit_gate_off = gate_analog_group[`PCG_BIT_CHARGE_TIME];
    assign cmp_vref_gate_off         = gate_analog_group[`PCG_BIT_CMP_VREF];
    assign comparator1_gate_off      = gate_comparator_group[`PCG_BIT_COMPARATOR1];
    assign comparator2_gate_off      = gate_comparator_group[`PCG_BIT_COMPARATOR2];
    assign capture1_gate_off         = gate_capture_compare_group[`PCG_BIT_CAPTURE1];
    assign capture2_gate_off         = gate_capture_compare_group[`PCG_BIT_CAPTURE2];
    assign capture3_gate_off         = gate_capture_compare_group[`PCG_BIT_CAPTURE3];
    assign capture4_gate_off         = gate_capture_compare_group[`PCG_BIT_CAPTURE4];
    assign capture5_gate_off         = gate_capture_compare_group[`PCG_BIT_CAPTURE5];
    assign compare1_gate_off         = gate_capture_compare_group[`PCG_BIT_COMPARE1];
    assign compare2_gate_off         = gate_capture_compare_group[`PCG_BIT_COMPARE2];
    assign compare3_gate_off         = gate_capture_compare_group[`PCG_BIT_COMPARE3];
    assign compare4_gate_off         = gate_capture_compare_group[`PCG_BIT_COMPARE4];
    assign compare5_gate_off         = gate_capture_compare_group[`PCG_BIT_COMPARE5];
    assign timer1_gate_off           = gate_timer_group[`PCG_BIT_TIMER1];
    assign timer2_gate_off           = gate_timer_group[`PCG_BIT_TIMER2];
    assign timer3_gate_off           = gate_timer_group[`PCG_BIT_TIMER3];
    assign timer4_gate_off           = gate_timer_group[`PCG_BIT_TIMER4];
    assign timer5_gate_off           = gate_timer_group[`PCG_BIT_TIMER5];
    assign uart1_gate_off            = gate_serial_group[`PCG_BIT_UART1];
    assign uart2_gate_off            = gate_serial_group[`PCG_BIT_UART2];
    assign uart3_gate_off            = gate_serial_group[`PCG_BIT_UART3];
    assign uart4_gate_off            = gate_serial_group[`PCG_BIT_UART4];
    assign uart5_gate_off            = gate_serial_group[`PCG_BIT_UART5];
    assign spi1_gate_off             = gate_serial_group[`PCG_BIT_SPI1];
    assign spi2_gate_off             = gate_serial_group[`PCG_BIT_SPI2];
    assign i2c1_gate_off             = gate_serial_group[`PCG_BIT_I2C1];
    assign i2c2_gate_off             = gate_serial_group[`PCG_BIT_I2C2];
    assign usb_gate_off              = gate_serial_group[`PCG_BIT_USB];
    assign rtc_gate_off              = gate_misc_group[`PCG_BIT_RTC];
    assign refclk_out_gate_off       = gate_misc_group[`PCG_BIT_REFCLK_OUT];
    assign parallel_port_gate_off    = gate_misc_group[`PCG_BIT_PARALLEL_PORT];

    // Lane numbering of every periph_* vector follows this list
    assign periph_gate_off = {
        parallel_port_gate_off,
        refclk_out_gate_off,
        rtc_gate_off,
        usb_gate_off,
        i2c2_gate_off,
        i2c1_gate_off,
        spi2_gate_off,
        spi1_gate_off,
        uart5_gate_off,
        uart4_gate_off,
        uart3_gate_off,
        uart2_gate_off,
        uart1_gate_off,
        timer5_gate_off,
        timer4_gate_off,
        timer3_gate_off,
        timer2_gate_off,
        timer1_gate_off,
        compare5_gate_off,
        compare4_gate_off,
        compare3_gate_off,
        compare2_gate_off,
        compare1_gate_off,
        capture5_gate_off,
        capture4_gate_off,
        capture3_gate_off,
        capture2_gate_off,
        capture1_gate_off,
        comparator2_gate_off,
        comparator1_gate_off,
        cmp_vref_gate_off,
        charge_time_unit_gate_off,
        adc_gate_off
    };

    // Software must have quiesced the peripheral; nothing is checked here
    assign periph_regs_blocked = periph_gate_off;

    genvar g;
    generate
        for (g = 0; g < `PCG_NUM_GATES; g = g + 1) begin : gate_lane
            pcg_clock_gate u_gate (
                .clk_in   (periph_clk_in[g]),
                .gate_off (periph_gate_off[g]),
                .clk_out  (periph_clk_out[g])
            );
        end
    endgenerate
endmodule

// ---- inc/pcg_map.vh ----
// Purpose: constants for the peripheral clock gating block
// Assumes: AXI4-Lite register bus, 32-bit data, byte addresses
// Notes:   one disable bit per present peripheral
// Operation
// - Disable bit stops the clock of its own peripheral only
// - Disabled peripheral ignores writes, reads invalid
// - Write 1 disables, 0 enables, reset 0
// - Group one: adc 0, charge time 8, vref 12
// - Group two: comparators at bits 0, 1
// - Capture 0-4, compare 16-20, timers 0-4
// - Serial, usb 24; misc 0, 1, 16
// - Bits exist only for present peripherals
`ifndef PCG_MAP_VH
`define PCG_MAP_VH
`define PCG_OFS_ANALOG     5'h00
`define PCG_OFS_COMPARATOR 5'h04
`define PCG_OFS_CAPCMP     5'h08
`define PCG_OFS_TIMER      5'h0C
`define PCG_OFS_SERIAL     5'h10
`define PCG_OFS_MISC       5'h14
`define PCG_MASK_ANALOG     32'h00001101
`define PCG_MASK_COMPARATOR 32'h00000003
`define PCG_MASK_CAPCMP     32'h001F001F
`define PCG_MASK_TIMER      32'h0000001F
`define PCG_MASK_SERIAL     32'h0103031F
`define PCG_MASK_MISC       32'h00010003
`define PCG_BIT_ADC           0
`define PCG_BIT_CHARGE_TIME   8
`define PCG_BIT_CMP_VREF      12
`define PCG_BIT_COMPARATOR1   0
`define PCG_BIT_COMPARATOR2   1
`define PCG_BIT_CAPTURE1      0
`define PCG_BIT_CAPTURE2      1
`define PCG_BIT_CAPTURE3      2
`define PCG_BIT_CAPTURE4      3
`define PCG_BIT_CAPTURE5      4
`define PCG_BIT_COMPARE1      16
`define PCG_BIT_COMPARE2      17
`define PCG_BIT_COMPARE3      18
`define PCG_BIT_COMPARE4      19
`define PCG_BIT_COMPARE5      20
`define PCG_BIT_TIMER1        0
`define PCG_BIT_TIMER2        1
`define PCG_BIT_TIMER3        2
`define PCG_BIT_TIMER4        3
`define PCG_BIT_TIMER5        4
`define PCG_BIT_UART1         0
`define PCG_BIT_UART2         1
`define PCG_BIT_UART3         2
`define PCG_BIT_UART4         3
`define PCG_BIT_UART5         4
`define PCG_BIT_SPI1          8
`define PCG_BIT_SPI2          9
`define PCG_BIT_I2C1          16
`define PCG_BIT_I2C2          17
`define PCG_BIT_USB           24
`define PCG_BIT_RTC           0
`define PCG_BIT_REFCLK_OUT    1
`define PCG_BIT_PARALLEL_PORT 16
`define PCG_RESET_VALUE     32'h00000000
`define PCG_NUM_GATES       33
`define PCG_RESP_OKAY       2'h0
`define PCG_RESP_SLVERR     2'h2
`endif

// ---- core/pcg_clock_gate.v ----
// Purpose: glitch-free clock gate for one peripheral clock
// Assumes: enable comes from the aclk domain
// Notes:   latch-free: enable retimed on the falling edge of gated clock
`timescale 1ns/1ps
module pcg_clock_gate (
    input  wire clk_in,
    input  wire gate_off,
    output wire clk_out
);
    reg sync_a;
    reg sync_b;
    reg sync_c;
    reg enable_low;

    // Three stages on the gated clock; a change counts once the last two agree
    always @(posedge clk_in) begin
        sync_a <= ~gate_off;
        sync_b <= sync_a;
        sync_c <= sync_b;
    end

    // Changes only while clk_in is low, so no runt pulses
    always @(negedge clk_in) begin
        if (sync_b == sync_c) begin
            enable_low <= sync_c;
        end
    end

    assign clk_out = clk_in & enable_low;
endmodule

// ---- verification/pcg_top_sva.sv ----
// Purpose: port checker for pcg_top
// Assumes: periph clocks at 20 MHz, so 8 aclk covers a gate settle
// Notes:   bound to every pcg_top
`timescale 1ns/1ps
module pcg_top_sva (
    input wire        aclk,
    input wire        aresetn,
    input wire [4:0]  s_axi_awaddr,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0]  s_axi_wstrb,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [31:0] s_axi_rdata,
    input wire        s_axi_rvalid,
    input wire [32:0] periph_clk_out,
    input wire [32:0] periph_gate_off,
    input wire [32:0] periph_regs_blocked
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence wr_at(logic [4:0] a);
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            && s_axi_awaddr == a && s_axi_wstrb == 4'hF;
    endsequence
    a_blocked_on_write: assert property (wr_at(5'h14) |=>
        periph_regs_blocked[32:30] == {$past(s_axi_wdata[16]), $past(s_axi_wdata[1]),
        $past(s_axi_wdata[0])}) else $error("blocked lanes wrong");
    a_reset_clears_gate: assert property (
        disable iff (1'b0) !aresetn |=> periph_gate_off == 33'h0) else $error("gate after reset");
    a_analog_lanes: assert property (wr_at(5'h00) |=>
        periph_gate_off[2:0] == {$past(s_axi_wdata[12]), $past(s_axi_wdata[8]),
        $past(s_axi_wdata[0])}) else $error("analog lanes wrong");
    a_comparator_lanes: assert property (wr_at(5'h04) |=>
        periph_gate_off[4:3] == $past(s_axi_wdata[1:0])) else $error("cmp lanes wrong");
    a_timer_lanes: assert property (wr_at(5'h0C) |=>
        periph_gate_off[19:15] == $past(s_axi_wdata[4:0])) else $error("timer lanes wrong");
    a_usb_lane: assert property (wr_at(5'h10) |=>
        periph_gate_off[29] == $past(s_axi_wdata[24])) else $error("usb lane wrong");
    a_unused_read_zero: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:25] == 7'h00) else $error("unused bits set");
    // Eight stable cycles cover three rising and one falling periph edge
    a_gated_clock_low: assert property ($stable(periph_gate_off) [*8] |->
        (periph_clk_out & periph_gate_off) == 33'h0) else $error("gated clock moves");
endmodule
bind pcg_top pcg_top_sva u_sva (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_rdata, .s_axi_rvalid, .periph_clk_out, .periph_gate_off,
    .periph_regs_blocked);

// ---- verification/pcg_periph_model.sv ----
// Purpose: peripheral side, free source clocks and edge counts
// Assumes: every peripheral clock runs at 20 MHz
// Notes:   counts show the bench whether a clock stopped
`timescale 1ns/1ps
module pcg_periph_model (
    input  wire [32:0] clk_gated,
    output reg  [32:0] clk_src
);
    int edges [33];
    initial clk_src = 33'h0;
    // Sources run free; stopping is the gate's job
    always #25 clk_src = ~clk_src;
    for (genvar i = 0; i < 33; i++) begin : g_lane
        always @(posedge clk_gated[i]) edges[i] <= edges[i] + 1;
    end
endmodule

// ---- verification/peripheral_clock_gating_tb.sv ----
// Purpose: self-checking bench for pcg_top
// Assumes: software clears each peripheral on bit, and idles usb, before gating
// Notes:   rows accumulate, so gate vectors carry earlier rows
`timescale 1ns/1ps
module peripheral_clock_gating_tb;
    typedef struct packed {
        logic [4:0]  a;
        logic [31:0] d;
        logic [31:0] rd;
        logic [32:0] g;
    } pcg_row_t;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [4:0]  awaddr = 5'h00;
    logic [4:0]  araddr = 5'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'h0;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    wire         awready, wready, bvalid, arready, rvalid;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    wire  [32:0] clk_src, clk_out, gate_off, blocked;
    int          err_total = 0;
    int          checks_done = 0;
    int          cyc = 0;
    int          s0, s2;
    logic [1:0]  r;
    logic [31:0] q;
    pcg_row_t    rows [10] = '{
        '{5'h00, 32'hFFFFFFFF, 32'h00001101, 33'h000000007},
        '{5'h04, 32'hFFFFFFFF, 32'h00000003, 33'h00000001F},
        '{5'h08, 32'hFFFFFFFF, 32'h001F001F, 33'h000007FFF},
        '{5'h0C, 32'hFFFFFFFF, 32'h0000001F, 33'h0000FFFFF},
        '{5'h10, 32'hFFFFFFFF, 32'h0103031F, 33'h03FFFFFFF}, // Usb already idle
        '{5'h14, 32'hFFFFFFFF, 32'h00010003, 33'h1FFFFFFFF},
        '{5'h00, 32'h00001000, 32'h00001000, 33'h1FFFFFFFC},
        '{5'h10, 32'h01000000, 32'h01000000, 33'h1E00FFFFC},
        '{5'h08, 32'h00010001, 32'h00010001, 33'h1E00F843C},
        '{5'h14, 32'h00000000, 32'h00000000, 33'h0200F843C}};
    always #12.5 aclk = ~aclk;
    pcg_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .periph_clk_in(clk_src), .periph_clk_out(clk_out),
        .periph_gate_off(gate_off), .periph_regs_blocked(blocked));
    pcg_periph_model u_periph (.clk_gated(clk_out), .clk_src(clk_src));
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        q = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total++;
            stop_test();
        end
    end
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        chk(gate_off, 33'h0);
        for (int i = 0; i < 10; i++) begin
            wr(rows[i].a, rows[i].d, 4'hF);
            chk(r, 2'h0);
            rd(rows[i].a);
            chk(q, rows[i].rd);
            chk(gate_off, rows[i].g);
        end
        $display("test table done");
        repeat (10) @(posedge aclk);
        s0 = u_periph.edges[0];
        s2 = u_periph.edges[2];
        repeat (20) @(posedge aclk);
        chk(33'(u_periph.edges[2] - s2), 33'h0);
        chk(33'(u_periph.edges[0] - s0), 33'hA);
        $display("test clock stop done");
        wr(5'h18, 32'hFFFFFFFF, 4'hF);
        chk(r, 2'h2);
        rd(5'h18);
        chk(q, 32'h0);
        chk(r, 2'h2);
        wr(5'h00, 32'h00000001, 4'h0);
        rd(5'h00);
        chk(q, 32'h00001000);
        $display("test refusals done");
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            rd(5'(i * 4));
            chk(q, 32'h0);
        end
        chk(gate_off, 33'h0);
        $display("test reset done");
        stop_test();
    end
endmodule
